// *** rtl/tps_pkg.sv ***
// constants for the transmitter power recycle sequencer
package tps_pkg;
  // ==========================================================
  // clock and time base
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_PERIOD_MS = 10;
  localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_PERIOD_MS;
  localparam int TICKS_PER_SEC = 1000 / TICK_PERIOD_MS;
  // ==========================================================
  // sequence times
  localparam int WARMUP_S = 30;
  localparam int WINDOW_S = 30;
  localparam int RESTART_DELAY_MS = 500;
  localparam int RESTART_PULSE_MS = 500;
  localparam int WARMUP_TICKS = WARMUP_S * TICKS_PER_SEC;
  localparam int WINDOW_TICKS = WINDOW_S * TICKS_PER_SEC;
  localparam int DELAY_TICKS = RESTART_DELAY_MS / TICK_PERIOD_MS;
  localparam int PULSE_TICKS = RESTART_PULSE_MS / TICK_PERIOD_MS;
  localparam int TMR_W = 13;
  // ==========================================================
  // restart limits
  localparam logic [2:0] LIMIT_TWO = 3'h2;
  localparam logic [2:0] LIMIT_FOUR = 3'h4;
  // ==========================================================
  // input vector positions
  localparam int IN_FIL_ON = 0;
  localparam int IN_FIL_OFF = 1;
  localparam int IN_HV_ON = 2;
  localparam int IN_AIR = 3;
  localparam int IN_PLATE_OVL = 4;
  localparam int IN_SCREEN_OVL = 5;
  localparam int IN_DRIVER_OVL = 6;
  localparam int IN_REFL_EXCESS = 7;
  localparam int IN_REFL_EN = 8;
  localparam int IN_FCLR = 9;
  localparam int IN_AR_DIS = 10;
  localparam int IN_RTEST = 11;
  localparam int IN_STRAP = 12;
  localparam int IN_W = 13;
  // ==========================================================
  // register map
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_HOURS = 8'h04;
  localparam logic [7:0] REG_CONTROL = 8'h08;
  localparam int CTL_ALLOW = 0;
  localparam int CTL_FCLR = 1;
  localparam logic CTL_ALLOW_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // state types
  typedef enum logic [1:0] {SQ_IDLE, SQ_BLOWER, SQ_FILAMENT, SQ_READY}
    tps_seq_e;
  typedef enum logic [1:0] {RC_IDLE, RC_DELAY, RC_PULSE} tps_rc_e;
endpackage

// *** rtl/tps_sequencer.sv ***
// transmitter power sequencer with overload latching and auto recycle
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module tps_sequencer #(
  parameter int TICK_CYCLES = tps_pkg::TICK_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [tps_pkg::IN_W-1:0] sw_in,
  output logic blower_relay,
  output logic filament_power_relay,
  output logic aux_power_enable,
  output logic warmup_delay_relay,
  output logic plate_control_relay,
  output logic exciter_override,
  output logic reflected_power_overload_trip,
  output logic [3:0] fault_lamp,
  output logic recycle_pulse_lamp,
  output logic recycle_lockout_lamp,
  output logic ready_lamp,
  output logic elapsed_hour_meter,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import tps_pkg::*;

  // ==========================================================
  // time base, synchronizer and debounce
  logic [16:0] div_reg, div_next;
  logic tick_reg, tick_next;
  logic [IN_W-1:0] s1_reg, s2_reg, samp_reg, samp_next;
  logic [IN_W-1:0] db_reg, db_next, dbp_reg;
  logic [IN_W-1:0] rise;

  always_comb begin
    div_next = div_reg + 17'h1;
    tick_next = 1'b0;
    if (div_reg == 17'(TICK_CYCLES - 1)) begin
      div_next = 17'h0;
      tick_next = 1'b1;
    end
    samp_next = tick_reg ? s2_reg : samp_reg;
    db_next = db_reg;
    if (tick_reg) begin
      // two agreeing tick samples make a stable level
      db_next = (s2_reg & samp_reg) | (db_reg & (s2_reg | samp_reg));
    end
  end

  assign rise = db_reg & ~dbp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= 17'h0;
      tick_reg <= 1'b0;
      s1_reg <= '0;
      s2_reg <= '0;
      samp_reg <= '0;
      db_reg <= '0;
      dbp_reg <= '0;
    end else begin
      div_reg <= div_next;
      tick_reg <= tick_next;
      s1_reg <= sw_in;
      s2_reg <= s1_reg;
      samp_reg <= samp_next;
      db_reg <= db_next;
      dbp_reg <= db_reg;
    end
  end

  // ==========================================================
  // strap capture after reset release
  logic [1:0] strap_wait_reg, strap_wait_next;
  logic [2:0] limit_reg, limit_next;

  always_comb begin
    strap_wait_next = strap_wait_reg;
    limit_next = limit_reg;
    if (strap_wait_reg != 2'h3) begin
      strap_wait_next = strap_wait_reg + 2'h1;
      if (strap_wait_reg == 2'h2) begin
        limit_next = s2_reg[IN_STRAP] ? LIMIT_FOUR : LIMIT_TWO;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_wait_reg <= 2'h0;
      limit_reg <= LIMIT_TWO;
    end else begin
      strap_wait_reg <= strap_wait_next;
      limit_reg <= limit_next;
    end
  end

  // ==========================================================
  // overload trips and fault lamps
  logic [3:0] trip, trip_p_reg, trip_rise;
  logic [3:0] fault_next;
  logic refl_trip_next, fclr_pulse;
  logic ctl_fclr_reg;

  assign trip = {reflected_power_overload_trip, db_reg[IN_DRIVER_OVL],
                 db_reg[IN_SCREEN_OVL], db_reg[IN_PLATE_OVL]};
  assign trip_rise = trip & ~trip_p_reg;
  assign fclr_pulse = rise[IN_FCLR] | ctl_fclr_reg;

  always_comb begin
    refl_trip_next = db_reg[IN_REFL_EXCESS] & db_reg[IN_REFL_EN];
    fault_next = fault_lamp;
    if (fclr_pulse) begin
      fault_next = 4'h0;
    end
    fault_next = fault_next | trip_rise;
  end

  // ==========================================================
  // recycle logic
  tps_rc_e rc_reg, rc_next;
  logic [TMR_W-1:0] rc_cnt_reg, rc_cnt_next, win_cnt_reg, win_cnt_next;
  logic win_run_reg, win_run_next;
  logic [2:0] att_reg, att_next;
  logic allow_reg;
  logic trigger, lockout, pulse_start, pulse_next, lock_next;

  assign trigger = (|trip_rise) | rise[IN_RTEST];
  assign lockout = (att_reg >= limit_reg);

  always_comb begin
    rc_next = rc_reg;
    rc_cnt_next = rc_cnt_reg;
    win_cnt_next = win_cnt_reg;
    win_run_next = win_run_reg;
    att_next = att_reg;
    pulse_start = 1'b0;
    if (win_run_reg && tick_reg) begin
      win_cnt_next = win_cnt_reg + 13'h1;
      if (win_cnt_reg == TMR_W'(WINDOW_TICKS - 1)) begin
        win_run_next = 1'b0;
        att_next = 3'h0;
      end
    end
    case (rc_reg)
      RC_IDLE: begin
        if (trigger && !lockout) begin
          rc_next = RC_DELAY;
          rc_cnt_next = '0;
          if (!win_run_reg) begin
            win_run_next = 1'b1;
            win_cnt_next = '0;
          end
        end
      end
      RC_DELAY: begin
        if (tick_reg) begin
          rc_cnt_next = rc_cnt_reg + 13'h1;
          if (rc_cnt_reg == TMR_W'(DELAY_TICKS - 1)) begin
            att_next = att_reg + 3'h1;
            rc_cnt_next = '0;
            if (allow_reg && !db_reg[IN_AR_DIS] && !lockout) begin
              rc_next = RC_PULSE;
              pulse_start = 1'b1;
            end else begin
              rc_next = RC_IDLE;
            end
          end
        end
      end
      RC_PULSE: begin
        if (tick_reg) begin
          rc_cnt_next = rc_cnt_reg + 13'h1;
          if (rc_cnt_reg == TMR_W'(PULSE_TICKS - 1)) begin
            rc_next = RC_IDLE;
          end
        end
      end
      default: rc_next = RC_IDLE;
    endcase
    pulse_next = (rc_next == RC_PULSE);
    lock_next = (att_next >= limit_reg);
  end

  // ==========================================================
  // power sequence
  tps_seq_e sq_reg, sq_next;
  logic [TMR_W-1:0] warm_reg, warm_next;
  logic hv_req_reg, hv_req_next, hv_cmd;
  logic plate_next;

  assign hv_cmd = rise[IN_HV_ON] | pulse_start;

  always_comb begin
    sq_next = sq_reg;
    warm_next = warm_reg;
    case (sq_reg)
      SQ_IDLE: begin
        if (rise[IN_FIL_ON] || hv_cmd) begin
          sq_next = SQ_BLOWER;
        end
      end
      SQ_BLOWER: begin
        warm_next = '0;
        if (db_reg[IN_AIR]) begin
          sq_next = SQ_FILAMENT;
        end
      end
      SQ_FILAMENT: begin
        if (tick_reg) begin
          warm_next = warm_reg + 13'h1;
          if (warm_reg == TMR_W'(WARMUP_TICKS - 1)) begin
            sq_next = SQ_READY;
          end
        end
      end
      SQ_READY: sq_next = SQ_READY;
      default: sq_next = SQ_IDLE;
    endcase
    if (sq_reg != SQ_IDLE && sq_reg != SQ_BLOWER && !db_reg[IN_AIR]) begin
      sq_next = SQ_BLOWER;
    end
    if (rise[IN_FIL_OFF]) begin
      sq_next = SQ_IDLE;
    end
    hv_req_next = hv_req_reg | hv_cmd;
    if ((|trip) || rise[IN_FIL_OFF]) begin
      hv_req_next = 1'b0;
    end
    plate_next = hv_req_next && (sq_next == SQ_READY) && !(|trip);
  end

  // ==========================================================
  // elapsed time totalizer
  logic [6:0] sub_reg, sub_next;
  logic [31:0] secs_reg, secs_next;

  always_comb begin
    sub_next = sub_reg;
    secs_next = secs_reg;
    if (filament_power_relay && tick_reg) begin
      sub_next = sub_reg + 7'h1;
      if (sub_reg == 7'(TICKS_PER_SEC - 1)) begin
        sub_next = 7'h0;
        secs_next = secs_reg + 32'h1;
      end
    end
  end

  // ==========================================================
  // state and output registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trip_p_reg <= 4'h0;
      fault_lamp <= 4'h0;
      reflected_power_overload_trip <= 1'b0;
      rc_reg <= RC_IDLE;
      rc_cnt_reg <= '0;
      win_cnt_reg <= '0;
      win_run_reg <= 1'b0;
      att_reg <= 3'h0;
      recycle_pulse_lamp <= 1'b0;
      recycle_lockout_lamp <= 1'b0;
      sq_reg <= SQ_IDLE;
      warm_reg <= '0;
      hv_req_reg <= 1'b0;
      blower_relay <= 1'b0;
      filament_power_relay <= 1'b0;
      aux_power_enable <= 1'b0;
      warmup_delay_relay <= 1'b0;
      plate_control_relay <= 1'b0;
      exciter_override <= 1'b1;
      ready_lamp <= 1'b0;
      elapsed_hour_meter <= 1'b0;
      sub_reg <= 7'h0;
      secs_reg <= 32'h0;
    end else begin
      trip_p_reg <= trip;
      fault_lamp <= fault_next;
      reflected_power_overload_trip <= refl_trip_next;
      rc_reg <= rc_next;
      rc_cnt_reg <= rc_cnt_next;
      win_cnt_reg <= win_cnt_next;
      win_run_reg <= win_run_next;
      att_reg <= att_next;
      recycle_pulse_lamp <= pulse_next;
      recycle_lockout_lamp <= lock_next;
      sq_reg <= sq_next;
      warm_reg <= warm_next;
      hv_req_reg <= hv_req_next;
      blower_relay <= (sq_next != SQ_IDLE);
      filament_power_relay <= (sq_next == SQ_FILAMENT) ||
                              (sq_next == SQ_READY);
      aux_power_enable <= (sq_next == SQ_FILAMENT) ||
                          (sq_next == SQ_READY);
      warmup_delay_relay <= (sq_next == SQ_READY);
      exciter_override <= (sq_next != SQ_READY);
      plate_control_relay <= plate_next;
      ready_lamp <= (sq_next == SQ_READY);
      elapsed_hour_meter <= (sq_next == SQ_FILAMENT) ||
                            (sq_next == SQ_READY);
      sub_reg <= sub_next;
      secs_reg <= secs_next;
    end
  end

  // ==========================================================
  // axi4-lite slave
  logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [7:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next;
  logic [3:0] ws_reg, ws_next;
  logic bvalid_next, rvalid_next, awready_next, wready_next, arready_next;
  logic [1:0] bresp_next, rresp_next;
  logic [31:0] rdata_next, status_word;
  logic allow_next, ctl_fclr_next, commit;

  assign status_word = {16'h0, limit_reg == LIMIT_FOUR, att_reg,
                        fault_lamp, recycle_pulse_lamp,
                        recycle_lockout_lamp, exciter_override, ready_lamp,
                        plate_control_relay, warmup_delay_relay,
                        filament_power_relay, blower_relay};

  always_comb begin
    aw_got_next = aw_got_reg | (s_axi_awvalid & s_axi_awready);
    w_got_next = w_got_reg | (s_axi_wvalid & s_axi_wready);
    awa_next = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awa_reg;
    wd_next = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wd_reg;
    ws_next = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : ws_reg;
    commit = aw_got_reg & w_got_reg & ~s_axi_bvalid;
    bvalid_next = s_axi_bvalid & ~s_axi_bready;
    bresp_next = s_axi_bresp;
    allow_next = allow_reg;
    ctl_fclr_next = 1'b0;
    if (commit) begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      if (awa_reg[7:2] == REG_CONTROL[7:2]) begin
        if (ws_reg[0]) begin
          allow_next = wd_reg[CTL_ALLOW];
          ctl_fclr_next = wd_reg[CTL_FCLR];
        end
      end else if (awa_reg[7:2] != REG_STATUS[7:2] &&
                   awa_reg[7:2] != REG_HOURS[7:2]) begin
        bresp_next = RESP_SLVERR;
      end
    end
    awready_next = ~aw_got_next & ~bvalid_next;
    wready_next = ~w_got_next & ~bvalid_next;
    rvalid_next = s_axi_rvalid & ~s_axi_rready;
    rdata_next = s_axi_rdata;
    rresp_next = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      case (s_axi_araddr[7:2])
        REG_STATUS[7:2]: rdata_next = status_word;
        REG_HOURS[7:2]: rdata_next = secs_reg;
        REG_CONTROL[7:2]: rdata_next = {31'h0, allow_reg};
        default: begin
          rdata_next = 32'h0;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
    arready_next = ~rvalid_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awa_reg <= 8'h0;
      wd_reg <= 32'h0;
      ws_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
      allow_reg <= CTL_ALLOW_RST;
      ctl_fclr_reg <= 1'b0;
    end else begin
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      s_axi_awready <= awready_next;
      s_axi_wready <= wready_next;
      s_axi_bvalid <= bvalid_next;
      s_axi_bresp <= bresp_next;
      s_axi_arready <= arready_next;
      s_axi_rvalid <= rvalid_next;
      s_axi_rdata <= rdata_next;
      s_axi_rresp <= rresp_next;
      allow_reg <= allow_next;
      ctl_fclr_reg <= ctl_fclr_next;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence fil_rises;
    $rose(filament_power_relay);
  endsequence

  chk_blower_first: assert property (
    fil_rises |-> $past(blower_relay))
    else $error("filament relay on without blower");
  chk_fil_air: assert property (fil_rises |-> $past(db_reg[IN_AIR]))
    else $error("filament relay on without air pressure");
  chk_aux_power: assert property (
    aux_power_enable == filament_power_relay)
    else $error("aux power not following filament relay");
  chk_warm_wait: assert property (
    $rose(warmup_delay_relay) |->
    $past(warm_reg) == TMR_W'(WARMUP_TICKS - 1))
    else $error("warm-up relay before full delay");
  chk_plate_warm: assert property (
    plate_control_relay |-> warmup_delay_relay)
    else $error("plate relay without warm-up");
  chk_override_hv: assert property (
    exciter_override != warmup_delay_relay)
    else $error("exciter override wrong");
  chk_trip_drop: assert property ((|trip) |=> !plate_control_relay)
    else $error("plate relay held during trip");
  chk_fault_set: assert property (
    (|trip_rise) |=>
    ((fault_lamp & $past(trip_rise)) == $past(trip_rise)))
    else $error("fault lamp not set by overload");
  chk_lockout_block: assert property (
    recycle_lockout_lamp |=> !$rose(recycle_pulse_lamp))
    else $error("restart pulse while locked out");
  chk_disable_pulse: assert property (
    db_reg[IN_AR_DIS] |=> !$rose(recycle_pulse_lamp))
    else $error("restart pulse while recycle disabled");
  chk_fil_off: assert property (
    rise[IN_FIL_OFF] |=>
    !blower_relay && !filament_power_relay && !plate_control_relay)
    else $error("filament off did not drop relays");
  chk_axi_bhold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid)
    else $error("write response dropped early");
endmodule // tps_sequencer
`default_nettype wire

// *** bench/tps_air_model.sv ***
// partner model: cabinet air pressure switch fed by the blowers
`timescale 1ns/10ps
`default_nettype none
module tps_air_model #(
  parameter int CLOSE_CYC = 200
) (
  input wire logic aclk,
  input wire logic blower_relay,
  output logic air_closed
);
  int cnt_reg;
  initial cnt_reg = 0;
  initial air_closed = 1'b0;
  // pressure builds only while the blowers run, opens at once when off
  always @(posedge aclk) begin
    cnt_reg <= blower_relay ? cnt_reg + 1 : 0;
    air_closed <= blower_relay && (cnt_reg >= CLOSE_CYC);
  end
endmodule // tps_air_model
`default_nettype wire

// *** bench/tps_sequencer_tb_top.sv ***
// testbench for the transmitter power recycle sequencer
`timescale 1ns/10ps
`default_nettype none
module tps_sequencer_tb_top;
  import tps_pkg::*;
  logic aclk, aresetn, air;
  logic [12:0] sw, sw_in;
  logic blower_relay, filament_power_relay, aux_power_enable;
  logic warmup_delay_relay, plate_control_relay, exciter_override;
  logic reflected_power_overload_trip, recycle_pulse_lamp;
  logic recycle_lockout_lamp, ready_lamp, elapsed_hour_meter;
  logic [3:0] fault_lamp, s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  assign sw_in = sw | (13'(air) << IN_AIR);
  tps_sequencer #(.TICK_CYCLES(10)) i_tps_sequencer (
    .aclk, .aresetn, .sw_in, .blower_relay, .filament_power_relay,
    .aux_power_enable, .warmup_delay_relay, .plate_control_relay,
    .exciter_override, .reflected_power_overload_trip, .fault_lamp,
    .recycle_pulse_lamp, .recycle_lockout_lamp, .ready_lamp,
    .elapsed_hour_meter, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  tps_air_model i_tps_air_model (.aclk(aclk), .blower_relay(blower_relay),
    .air_closed(air));
  // ==========================================================
  // clock, watchdog, report
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial forever begin
    @(posedge aclk);
    cyc++;
    if (cyc >= 90000) begin
      n_mismatch++;
      print_verdict;
    end
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input string nm, input logic [33:0] seen, input logic [33:0] ex);
    n_checks++;
    if (seen !== ex) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  // ==========================================================
  // register bus and switch tasks
  task wr(input logic [7:0] a, input logic [31:0] v);
    bit aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task press(input int b);
    @(posedge aclk);
    sw[b] <= 1'b1;
    repeat (60) @(posedge aclk);
    sw[b] <= 1'b0;
    repeat (60) @(posedge aclk);
  endtask
  // overload or test trigger, then the restart outcome
  task ovl(input int b, input logic [3:0] lamps, input logic p,
           input logic lk);
    @(posedge aclk);
    sw[b] <= 1'b1;
    repeat (60) @(posedge aclk);
    if (b != IN_RTEST) chk("plate_trip", plate_control_relay, 0);
    sw[b] <= 1'b0;
    repeat (640) @(posedge aclk);
    chk("pulse_on", recycle_pulse_lamp, p);
    repeat (500) @(posedge aclk);
    chk("pulse_off", recycle_pulse_lamp, 0);
    if (p) chk("restart_hv", plate_control_relay, 1);
    chk("lamps", fault_lamp, lamps);
    chk("lockout", recycle_lockout_lamp, lk);
  endtask
  // ==========================================================
  // scenarios
  task t_reset;
    chk("rst_relays", {blower_relay, filament_power_relay}, 0);
    chk("rst_override", exciter_override, 1);
    rd(REG_STATUS);
    chk("status", {r, d}, 34'h20);
    rd(REG_CONTROL);
    chk("control", {r, d}, {RESP_OKAY, 31'h0, CTL_ALLOW_RST});
    rd(8'h40);
    chk("unmapped_rd", {r, d}, {RESP_SLVERR, 32'h0});
    wr(8'h40, 32'h1);
    chk("unmapped_wr", r, RESP_SLVERR);
    wr(REG_CONTROL, 32'h1);
    chk("control_wr", r, RESP_OKAY);
  endtask
  task t_power;
    int i;
    press(IN_FIL_ON);
    chk("blower_first", blower_relay, 1);
    chk("no_air_no_fil", filament_power_relay, 0);
    for (i = 0; i < 1000 && filament_power_relay !== 1'b1; i++)
      @(posedge aclk);
    chk("aux", {filament_power_relay, aux_power_enable}, 3);
    chk("hours_run", elapsed_hour_meter, 1);
    repeat (29000) @(posedge aclk);
    chk("warm_early", warmup_delay_relay, 0);
    repeat (1100) @(posedge aclk);
    chk("warm_done", {warmup_delay_relay, ready_lamp}, 3);
    chk("override_off", exciter_override, 0);
    press(IN_HV_ON);
    chk("hv_on", plate_control_relay, 1);
  endtask
  task t_reflect;
    sw[IN_REFL_EXCESS] <= 1'b1;
    repeat (60) @(posedge aclk);
    chk("refl_dis", reflected_power_overload_trip, 0);
    sw[IN_REFL_EN] <= 1'b1;
    repeat (60) @(posedge aclk);
    chk("refl_en", reflected_power_overload_trip, 1);
    sw[IN_REFL_EXCESS] <= 1'b0;
    repeat (60) @(posedge aclk);
    chk("refl_lamp", fault_lamp, 4'h8);
    press(IN_FCLR);
    chk("fault_clr", fault_lamp, 4'h0);
  endtask
  task t_window;
    int i;
    for (i = 0; i < 32000 && recycle_lockout_lamp !== 1'b0; i++)
      @(posedge aclk);
    chk("window_clr", recycle_lockout_lamp, 0);
    rd(REG_STATUS);
    chk("attempts", d[14:12], 3'h0);
  endtask
  // second reset with four-restart strap, pulses held off by control
  task t_strap;
    sw <= 13'h1000;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(REG_STATUS);
    chk("limit_four", d[15], 1);
    wr(REG_CONTROL, 32'h0);
    rd(REG_CONTROL);
    chk("allow_off", {r, d}, {RESP_OKAY, 32'h0});
    press(IN_HV_ON);
    chk("hv_from_off", blower_relay, 1);
    repeat (3) ovl(IN_RTEST, 4'h0, 0, 0);
    ovl(IN_RTEST, 4'h0, 0, 1);
  endtask
  initial begin
    {sw, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    t_reset;
    t_power;
    ovl(IN_PLATE_OVL, 4'h1, 1, 0);
    ovl(IN_SCREEN_OVL, 4'h3, 1, 1);
    ovl(IN_DRIVER_OVL, 4'h7, 0, 1);
    wr(REG_CONTROL, 32'h3);
    repeat (2) @(posedge aclk);
    chk("ctl_clear", fault_lamp, 4'h0);
    t_reflect;
    t_window;
    ovl(IN_RTEST, 4'h0, 1, 0);
    sw[IN_AR_DIS] <= 1'b1;
    ovl(IN_RTEST, 4'h0, 0, 1);
    press(IN_FIL_OFF);
    chk("off", {blower_relay, filament_power_relay}, 0);
    chk("off_hv", {plate_control_relay, warmup_delay_relay}, 0);
    chk("off_meter", elapsed_hour_meter, 0);
    chk("off_override", exciter_override, 1);
    t_strap;
    print_verdict;
  end
endmodule // tps_sequencer_tb_top
`default_nettype wire
